/* File: design/ssp_tm_map.svh */
// offsets, frame codes and field values for the ssp task management block
`ifndef SSP_TM_MAP_SVH
`define SSP_TM_MAP_SVH
`define FT_DATA 8'h01
`define FT_XRDY 8'h05
`define FT_TASK 8'h16
`define IU_BASE 11'h018
`define TASK_LAST 11'h033
`define IDX_MAX 11'h7ff
`define FN_ABT 8'h01
`define FN_ABS 8'h02
`define FN_CTS 8'h04
`define FN_LUR 8'h08
`define FN_ITR 8'h10
`define FN_ACA 8'h40
`define FN_QT 8'h80
`define FN_QTS 8'h81
`define FN_QAE 8'h82
`define RC_DONE 8'h00
`define RC_NSUP 8'h04
`define RC_OK 8'h08
`define RC_BADLU 8'h09
`define DP_RESP 2'b01
`define DEP_ONE 2'b01
`define DEP_MANY 2'b10
`define SK_UA 4'h6
`define ASC_CLR 16'h2f00
`define ASC_RST 16'h2900
`define ASC_NXL 16'h2907
`define XRDY_LAST 4'hc
`define R_XOFF 8'h00
`define R_XLEN 8'h04
`define R_CTRL 8'h08
`define R_STAT 8'h0c
`define R_WCNT 8'h10
`endif

/* File: design/ssp_tm_pkg.sv */
// state types for the ssp task management block
package ssp_tm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_RESP = 3'b100
  } tm_state_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_XRDY = 4'b0010,
    TX_DHDR = 4'b0100,
    TX_DATA = 4'b1000
  } tx_state_t;
endpackage : ssp_tm_pkg

/* File: design/ssp_task_mgmt_and_xfer_ready.sv */
// ssp target transport: task management, transfer ready and data frames
`timescale 1ns/100ps
`include "ssp_tm_map.svh"
module ssp_task_mgmt_and_xfer_ready (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [1:0] rx_init,
  input wire logic cmd_new,
  input wire logic [15:0] cmd_tag,
  input wire logic [1:0] cmd_init,
  input wire logic cmd_done,
  input wire logic [15:0] done_tag,
  input wire logic [1:0] done_init,
  input wire logic ua_clear,
  input wire logic [1:0] ua_clear_init,
  input wire logic def_err,
  input wire logic [3:0] def_key,
  input wire logic [15:0] def_code,
  input wire logic src_valid,
  input wire logic [7:0] src_byte,
  input wire logic src_last,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  output logic resp_valid_q,
  output logic [1:0] resp_init_q,
  output logic [7:0] resp_code_q,
  output logic [1:0] response_content_selector_q,
  output logic [23:0] resp_info_q,
  output logic [7:0] task_abort_q,
  output logic resv_release_q,
  output logic tx_valid_q,
  output logic [7:0] tx_byte_q,
  output logic tx_last_q,
  output logic src_ready_q,
  output logic wr_valid_q,
  output logic [7:0] wr_byte_q
);

  localparam int NT = 8;
  localparam int NI = 4;

  ssp_tm_pkg::tm_state_t st_q;
  ssp_tm_pkg::tx_state_t tx_q;

  logic [10:0] idx_q;
  logic [10:0] cur_idx;
  logic [10:0] iu;
  logic [7:0] ftype_q;
  logic [7:0] task_mgmt_function_code_q;
  logic [15:0] managed_task_tag_q;
  logic lu_bad_q;
  logic [1:0] rinit_q;
  logic tm_go;

  logic [NT-1:0] tv_q;
  logic [15:0] tt_q [NT];
  logic [1:0] ti_q [NT];
  logic [NT-1:0] kill;
  logic [NT-1:0] hit;
  logic [NI-1:0] init_has;
  logic [2:0] free_idx;
  logic free_ok;
  logic do_act;

  logic [NI-1:0] ua_q;
  logic [15:0] ua_asc_q [NI];
  logic [1:0] pending_condition_depth;
  logic [7:0] rc;
  logic [23:0] info;

  logic [31:0] xoff_q;
  logic [31:0] xlen_q;
  logic [31:0] soff_q;
  logic [31:0] grant_q;
  logic [31:0] wcnt_q;
  logic go_q;
  logic ovr_q;
  logic [3:0] cnt_q;
  logic dat_byte;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic known_f(input logic [7:0] c);
    case (c)
      `FN_ABT, `FN_ABS, `FN_CTS, `FN_LUR, `FN_ITR: known_f = 1'b1;
      `FN_QT, `FN_QTS, `FN_QAE: known_f = 1'b1;
      default: known_f = 1'b0;
    endcase
  endfunction : known_f

  // tags live per nexus, so the initiator must match as well
  function automatic logic kill_f(input logic [7:0] c, input logic [15:0] et,
      input logic [1:0] ei, input logic [15:0] rt, input logic [1:0] ri);
    case (c)
      `FN_ABT: kill_f = (et == rt) && (ei == ri);
      `FN_ABS, `FN_ITR: kill_f = (ei == ri);
      `FN_CTS, `FN_LUR: kill_f = 1'b1;
      default: kill_f = 1'b0;
    endcase
  endfunction : kill_f

  function automatic logic [7:0] xrdy_f(input logic [3:0] c, input logic [31:0] o,
      input logic [31:0] l);
    case (c)
      4'h0: xrdy_f = `FT_XRDY;
      4'h1: xrdy_f = o[31:24];
      4'h2: xrdy_f = o[23:16];
      4'h3: xrdy_f = o[15:8];
      4'h4: xrdy_f = o[7:0];
      4'h5: xrdy_f = l[31:24];
      4'h6: xrdy_f = l[23:16];
      4'h7: xrdy_f = l[15:8];
      4'h8: xrdy_f = l[7:0];
      default: xrdy_f = 8'h00;
    endcase
  endfunction : xrdy_f

  ////////////////////////////////////////////////////////////////////
  // receive parsing

  assign cur_idx = rx_sof ? 11'h000 : idx_q;
  assign iu = cur_idx - `IU_BASE;
  // only a whole 28-byte task unit is acted on
  assign tm_go = rx_valid && rx_eof && (ftype_q == `FT_TASK) && (cur_idx == `TASK_LAST);
  assign dat_byte = rx_valid && (ftype_q == `FT_DATA) && (cur_idx >= `IU_BASE);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      idx_q <= 11'h000;
      ftype_q <= 8'h00;
      rinit_q <= 2'b00;
      lu_bad_q <= 1'b0;
      task_mgmt_function_code_q <= 8'h00;
      managed_task_tag_q <= 16'h0000;
    end else if (rx_valid) begin
      idx_q <= (cur_idx == `IDX_MAX) ? cur_idx : cur_idx + 11'h001;
      if (cur_idx == 11'h000) begin
        ftype_q <= rx_byte;
        rinit_q <= rx_init;
        lu_bad_q <= 1'b0;
      end else if (ftype_q == `FT_TASK && cur_idx >= `IU_BASE) begin
        case (iu)
          11'h000, 11'h001, 11'h002, 11'h003,
          11'h004, 11'h005, 11'h006, 11'h007: lu_bad_q <= lu_bad_q | (rx_byte != 8'h00);
          11'h00a: task_mgmt_function_code_q <= rx_byte;
          11'h00c: managed_task_tag_q[15:8] <= rx_byte;
          11'h00d: managed_task_tag_q[7:0] <= rx_byte;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // task table

  always_comb begin
    kill = '0;
    hit = '0;
    init_has = '0;
    free_idx = 3'h0;
    free_ok = 1'b0;
    for (int i = NT - 1; i >= 0; i--) begin
      kill[i] = tv_q[i] && kill_f(task_mgmt_function_code_q, tt_q[i], ti_q[i],
                                  managed_task_tag_q, rinit_q);
      hit[i] = tv_q[i] && (tt_q[i] == managed_task_tag_q) && (ti_q[i] == rinit_q);
      if (tv_q[i]) init_has[ti_q[i]] = 1'b1;
      if (!tv_q[i]) begin
        free_idx = 3'(i);
        free_ok = 1'b1;
      end
    end
  end

  assign do_act = (st_q == ssp_tm_pkg::ST_EXEC) && !lu_bad_q;

  for (genvar i = 0; i < NT; i++) begin : g_task
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        tv_q[i] <= 1'b0;
        tt_q[i] <= 16'h0000;
        ti_q[i] <= 2'b00;
      end else if (do_act && kill[i]) begin
        tv_q[i] <= 1'b0;
      end else if (cmd_done && tv_q[i] && tt_q[i] == done_tag && ti_q[i] == done_init) begin
        tv_q[i] <= 1'b0;
      end else if (cmd_new && free_ok && free_idx == 3'(i)) begin
        tv_q[i] <= 1'b1;
        tt_q[i] <= cmd_tag;
        ti_q[i] <= cmd_init;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // unit attention per initiator; a new condition wins over a clear

  for (genvar j = 0; j < NI; j++) begin : g_ua
    logic set_cl;
    logic set_rs;
    logic set_nx;
    assign set_cl = do_act && task_mgmt_function_code_q == `FN_CTS && rinit_q != 2'(j) && init_has[j];
    assign set_rs = do_act && task_mgmt_function_code_q == `FN_LUR;
    assign set_nx = do_act && task_mgmt_function_code_q == `FN_ITR && rinit_q == 2'(j);
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        ua_q[j] <= 1'b0;
        ua_asc_q[j] <= 16'h0000;
      end else if (set_cl) begin
        ua_q[j] <= 1'b1;
        ua_asc_q[j] <= `ASC_CLR;
      end else if (set_rs) begin
        ua_q[j] <= 1'b1;
        ua_asc_q[j] <= `ASC_RST;
      end else if (set_nx) begin
        ua_q[j] <= 1'b1;
        ua_asc_q[j] <= `ASC_NXL;
      end else if (ua_clear && ua_clear_init == 2'(j)) begin
        ua_q[j] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // response selection

  always_comb begin
    info = 24'h00_0000;
    pending_condition_depth = (ua_q[rinit_q] && def_err) ? `DEP_MANY : `DEP_ONE;
    if (lu_bad_q) begin
      rc = `RC_BADLU;
    end else begin
      case (task_mgmt_function_code_q)
        `FN_QT: rc = (|hit) ? `RC_OK : `RC_DONE;
        `FN_QTS: rc = (|tv_q) ? `RC_OK : `RC_DONE;
        `FN_QAE: rc = (ua_q[rinit_q] || def_err) ? `RC_OK : `RC_DONE;
        default: rc = known_f(task_mgmt_function_code_q) ? `RC_DONE : `RC_NSUP;
      endcase
      // attention ranks above a deferred error
      if (task_mgmt_function_code_q == `FN_QAE && ua_q[rinit_q]) begin
        info = {2'b00, pending_condition_depth, `SK_UA, ua_asc_q[rinit_q]};
      end else if (task_mgmt_function_code_q == `FN_QAE && def_err) begin
        info = {2'b00, pending_condition_depth, def_key, def_code};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q <= ssp_tm_pkg::ST_IDLE;
    end else begin
      case (st_q)
        ssp_tm_pkg::ST_IDLE: if (tm_go) st_q <= ssp_tm_pkg::ST_EXEC;
        ssp_tm_pkg::ST_EXEC: st_q <= ssp_tm_pkg::ST_RESP;
        ssp_tm_pkg::ST_RESP: st_q <= ssp_tm_pkg::ST_IDLE;
        default: st_q <= ssp_tm_pkg::ST_IDLE;
      endcase
    end
  end

  // answer leaves on the same edge that applies the action
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      resp_valid_q <= 1'b0;
      resp_init_q <= 2'b00;
      resp_code_q <= 8'h00;
      response_content_selector_q <= 2'b00;
      resp_info_q <= 24'h00_0000;
      task_abort_q <= 8'h00;
      resv_release_q <= 1'b0;
    end else begin
      resp_valid_q <= (st_q == ssp_tm_pkg::ST_EXEC);
      task_abort_q <= do_act ? kill : 8'h00;
      resv_release_q <= do_act && task_mgmt_function_code_q == `FN_LUR;
      if (st_q == ssp_tm_pkg::ST_EXEC) begin
        resp_init_q <= rinit_q;
        resp_code_q <= rc;
        response_content_selector_q <= `DP_RESP;
        resp_info_q <= info;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      xoff_q <= 32'h0000_0000;
      xlen_q <= 32'h0000_0000;
      go_q <= 1'b0;
    end else begin
      if (wr && addr == `R_XOFF) xoff_q <= {wdata[31:2], 2'b00};
      if (wr && addr == `R_XLEN) xlen_q <= wdata;
      go_q <= (wr && addr == `R_CTRL && wdata[0]) || (go_q && tx_q != ssp_tm_pkg::TX_IDLE);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `R_XOFF: rdata_q <= xoff_q;
        `R_XLEN: rdata_q <= xlen_q;
        `R_CTRL: rdata_q <= {31'h0000_0000, go_q};
        `R_STAT: rdata_q <= {16'h0000, tv_q, ua_q, 1'b0, ovr_q,
                             tx_q != ssp_tm_pkg::TX_IDLE, st_q != ssp_tm_pkg::ST_IDLE};
        `R_WCNT: rdata_q <= wcnt_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write data intake, policed against the grant

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_valid_q <= 1'b0;
      wr_byte_q <= 8'h00;
      wcnt_q <= 32'h0000_0000;
      grant_q <= 32'h0000_0000;
      ovr_q <= 1'b0;
    end else begin
      wr_valid_q <= dat_byte && (wcnt_q < grant_q);
      if (dat_byte) wr_byte_q <= rx_byte;
      if (tx_q == ssp_tm_pkg::TX_IDLE && go_q) begin
        wcnt_q <= 32'h0000_0000;
        grant_q <= xlen_q;
      end else if (dat_byte && wcnt_q < grant_q) begin
        wcnt_q <= wcnt_q + 32'h0000_0001;
      end
      // excess bytes get no wr_valid_q and no count but still load wr_byte_q; the sticky flag records them
      ovr_q <= (dat_byte && wcnt_q >= grant_q) || (ovr_q && !(wr && addr == `R_CTRL && wdata[1]));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit: transfer ready has priority over read data

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_q <= ssp_tm_pkg::TX_IDLE;
      tx_valid_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_last_q <= 1'b0;
      src_ready_q <= 1'b0;
      cnt_q <= 4'h0;
      soff_q <= 32'h0000_0000;
    end else begin
      case (tx_q)
        ssp_tm_pkg::TX_IDLE: begin
          tx_valid_q <= 1'b0;
          tx_last_q <= 1'b0;
          cnt_q <= 4'h0;
          if (go_q) begin
            tx_q <= ssp_tm_pkg::TX_XRDY;
            soff_q <= xoff_q;
          end else if (src_valid) begin
            tx_q <= ssp_tm_pkg::TX_DHDR;
          end
        end
        ssp_tm_pkg::TX_XRDY: begin
          tx_valid_q <= 1'b1;
          tx_byte_q <= xrdy_f(cnt_q, soff_q, grant_q);
          tx_last_q <= (cnt_q == `XRDY_LAST);
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `XRDY_LAST) tx_q <= ssp_tm_pkg::TX_IDLE;
        end
        ssp_tm_pkg::TX_DHDR: begin
          tx_valid_q <= 1'b1;
          tx_byte_q <= `FT_DATA;
          tx_last_q <= 1'b0;
          src_ready_q <= 1'b1;
          tx_q <= ssp_tm_pkg::TX_DATA;
        end
        ssp_tm_pkg::TX_DATA: begin
          tx_valid_q <= src_valid;
          tx_last_q <= src_valid && src_last;
          if (src_valid) tx_byte_q <= src_byte;
          if (src_valid && src_last) begin
            src_ready_q <= 1'b0;
            tx_q <= ssp_tm_pkg::TX_IDLE;
          end
        end
        default: tx_q <= ssp_tm_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_xrdy_go;
    tx_q == ssp_tm_pkg::TX_IDLE && go_q;
  endsequence
  sequence s_xrdy_frame;
    tx_valid_q && tx_byte_q == `FT_XRDY ##4 tx_byte_q[1:0] == 2'b00 ##8 tx_last_q;
  endsequence
  sequence s_task_in;
    st_q == ssp_tm_pkg::ST_IDLE && tm_go;
  endsequence

  a_xrdy_frame: assert property (s_xrdy_go |=> ##1 s_xrdy_frame)
    else $error("transfer ready frame malformed");
  a_resp_once: assert property (s_task_in |=> ##1 resp_valid_q ##1 !resp_valid_q)
    else $error("task request not answered exactly once");
  a_lu_reject: assert property (st_q == ssp_tm_pkg::ST_EXEC && lu_bad_q
      |=> resp_code_q == `RC_BADLU && task_abort_q == 8'h00 && !resv_release_q)
    else $error("bad logical unit not rejected");
  a_unsup_code: assert property (do_act && !known_f(task_mgmt_function_code_q)
      |=> resp_code_q == `RC_NSUP && task_abort_q == 8'h00)
    else $error("unknown function not refused");
  a_content_sel: assert property (resp_valid_q |-> response_content_selector_q == `DP_RESP)
    else $error("response selector wrong");
  a_qae_zero: assert property (do_act && task_mgmt_function_code_q == `FN_QAE
      && !ua_q[rinit_q] && !def_err |=> resp_code_q == `RC_DONE && resp_info_q == 24'h00_0000)
    else $error("empty event query answer wrong");
  a_abort_tag: assert property (do_act && task_mgmt_function_code_q == `FN_ABT
      |=> task_abort_q == $past(hit))
    else $error("abort task hit wrong entry");
  a_clear_all: assert property (do_act && task_mgmt_function_code_q == `FN_CTS
      |=> task_abort_q == $past(tv_q))
    else $error("clear task set left tasks");
  a_nexus_ua: assert property (do_act && task_mgmt_function_code_q == `FN_ITR
      |=> ua_q[$past(rinit_q)] && ua_asc_q[$past(rinit_q)] == `ASC_NXL)
    else $error("nexus loss attention missing");
  a_write_grant: assert property (wr_valid_q |-> wcnt_q <= grant_q && wcnt_q != 32'h0000_0000)
    else $error("write data beyond grant");

endmodule : ssp_task_mgmt_and_xfer_ready

/* File: tb/ssp_initiator_model.sv */
// initiator-side model: sends task and data frames, collects outgoing frames
`timescale 1ns/100ps
module ssp_initiator_model (
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_sof,
  output logic rx_eof,
  output logic [1:0] rx_init,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_last_q
);
  logic [7:0] txq[$];
  int last_at = -1;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_init = 2'b00;
  end
  always @(posedge clock) begin
    if (tx_valid_q === 1'b1) begin
      if (tx_last_q === 1'b1) last_at = txq.size();
      txq.push_back(tx_byte_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // the released rx_byte shows the inverse of the last byte, so a stale byte is never mistaken for data
  task automatic send_frame(input logic [1:0] ini, input logic [7:0] fb[$]);
    for (int i = 0; i < fb.size(); i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_byte <= fb[i];
      rx_sof <= (i == 0);
      rx_eof <= (i == fb.size() - 1);
      rx_init <= (i == 0) ? ini : ~ini;
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_byte <= ~fb[fb.size() - 1];
  endtask : send_frame
  task automatic send_task(input logic [1:0] ini, input logic [7:0] lu, input logic [7:0] fn, input logic [15:0] tag);
    logic [7:0] fb[$];
    for (int i = 0; i < 52; i++) fb.push_back(8'h00);
    fb[0] = `FT_TASK;
    fb[31] = lu;
    fb[34] = fn;
    fb[36] = tag[15:8];
    fb[37] = tag[7:0];
    send_frame(ini, fb);
  endtask : send_task
  // grant is kept by the caller choosing n; overrun scenarios exceed it on purpose
  task automatic send_data(input logic [1:0] ini, input int n);
    logic [7:0] fb[$];
    fb.push_back(`FT_DATA);
    for (int i = 1; i < 24 + n; i++) fb.push_back(8'(i));
    send_frame(ini, fb);
  endtask : send_data
endmodule : ssp_initiator_model

/* File: tb/test_ssp_task_mgmt_and_xfer_ready.sv */
// testbench for the ssp task management and transfer ready block
`timescale 1ns/100ps
`include "ssp_tm_map.svh"
module test_ssp_task_mgmt_and_xfer_ready;
  logic clock = 1'b0, reset_n = 1'b0, rx_valid, rx_sof, rx_eof, cmd_new = 1'b0, cmd_done = 1'b0;
  logic ua_clear = 1'b0, def_err = 1'b0, src_valid = 1'b0, src_last = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] rx_byte, src_byte = 8'h00, addr = 8'h00;
  logic [1:0] rx_init, cmd_init = 2'b00, done_init = 2'b00, ua_clear_init = 2'b00;
  logic [15:0] cmd_tag = 16'h0000, done_tag = 16'h0000, def_code = 16'h0000;
  logic [3:0] def_key = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata_q;
  logic resp_valid_q, resv_release_q, tx_valid_q, tx_last_q, src_ready_q, wr_valid_q;
  logic [1:0] resp_init_q, response_content_selector_q, got_sel, got_init;
  logic [7:0] resp_code_q, task_abort_q, tx_byte_q, wr_byte_q, got_code, got_abort;
  logic [23:0] resp_info_q, got_info;
  logic got_rel;
  logic [7:0] wr_last;
  int n_mismatch = 0, tests_run = 0, resp_cnt = 0, wr_cnt = 0;
  always #50 clock = ~clock;
  ssp_task_mgmt_and_xfer_ready u_dut (.clock, .reset_n, .rx_valid, .rx_byte, .rx_sof, .rx_eof, .rx_init,
    .cmd_new, .cmd_tag, .cmd_init, .cmd_done, .done_tag, .done_init, .ua_clear, .ua_clear_init,
    .def_err, .def_key, .def_code, .src_valid, .src_byte, .src_last, .addr, .wdata, .wr, .rd, .rdata_q,
    .resp_valid_q, .resp_init_q, .resp_code_q, .response_content_selector_q, .resp_info_q,
    .task_abort_q, .resv_release_q, .tx_valid_q, .tx_byte_q, .tx_last_q, .src_ready_q, .wr_valid_q,
    .wr_byte_q);
  ssp_initiator_model u_init (.clock, .rx_valid, .rx_byte, .rx_sof, .rx_eof, .rx_init,
    .tx_valid_q, .tx_byte_q, .tx_last_q);
  always @(posedge clock) begin
    if (wr_valid_q === 1'b1) begin
      wr_cnt++;
      wr_last = wr_byte_q;
    end
    if (resp_valid_q === 1'b1) begin
      resp_cnt++;
      {got_code, got_sel, got_info, got_init} = {resp_code_q, response_content_selector_q, resp_info_q, resp_init_q};
      {got_abort, got_rel} = {task_abort_q, resv_release_q};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset;
    @(posedge clock) reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clock) wr <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock) {rd, addr} <= {1'b1, a};
    @(posedge clock) rd <= 1'b0;
    #1 v = rdata_q;
  endtask : rd32
  task automatic add(input logic [15:0] t, input logic [1:0] i);
    @(posedge clock) {cmd_new, cmd_tag, cmd_init} <= {1'b1, t, i};
    @(posedge clock) cmd_new <= 1'b0;
  endtask : add
  task automatic fin(input logic [15:0] t, input logic [1:0] i);
    @(posedge clock) {cmd_done, done_tag, done_init} <= {1'b1, t, i};
    @(posedge clock) cmd_done <= 1'b0;
  endtask : fin
  task automatic ua_pulse(input logic [1:0] i);
    @(posedge clock) {ua_clear, ua_clear_init} <= {1'b1, i};
    @(posedge clock) ua_clear <= 1'b0;
  endtask : ua_pulse
  task automatic tm(input logic [1:0] ini, input logic [7:0] lu, input logic [7:0] fn, input logic [15:0] tag,
    input logic [7:0] ec, input logic [23:0] ei, input logic [7:0] ea);
    int c0;
    c0 = resp_cnt;
    u_init.send_task(ini, lu, fn, tag);
    repeat (10) @(posedge clock);
    chk("resp_count", 32'(c0 + 1), 32'(resp_cnt));
    chk("resp_code", {24'h0, ec}, {24'h0, got_code});
    chk("resp_sel", {30'h0, `DP_RESP}, {30'h0, got_sel});
    chk("resp_init", {30'h0, ini}, {30'h0, got_init});
    chk("resp_info", {8'h0, ei}, {8'h0, got_info});
    chk("task_abort", {24'h0, ea}, {24'h0, got_abort});
    chk("release", {31'h0, fn == `FN_LUR && lu == 8'h00}, {31'h0, got_rel});
  endtask : tm
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_abort;
    do_reset;
    add(16'h1234, 2'd0);
    add(16'h5678, 2'd1);
    add(16'h9abc, 2'd0);
    tm(0, 8'h01, `FN_ABT, 16'h1234, `RC_BADLU, 0, 0);
    tm(0, 0, `FN_QT, 16'h1234, `RC_OK, 0, 0);
    tm(1, 0, `FN_QT, 16'h1234, `RC_DONE, 0, 0);
    tm(0, 0, `FN_ABT, 16'h9abc, `RC_DONE, 0, 8'h04);
    tm(0, 0, `FN_ABS, 16'h5678, `RC_DONE, 0, 8'h01);
    tm(1, 0, `FN_QTS, 0, `RC_OK, 0, 0);
    tm(1, 0, `FN_ITR, 0, `RC_DONE, 0, 8'h02);
    tm(1, 0, `FN_QTS, 0, `RC_DONE, 0, 0);
    add(16'h7777, 2'd2);
    fin(16'h7777, 2'd2);
    tm(2, 0, `FN_QTS, 0, `RC_DONE, 0, 0);
    tm(1, 0, `FN_QAE, 0, `RC_OK, {2'b00, `DEP_ONE, `SK_UA, `ASC_NXL}, 0);
    ua_pulse(1);
    tm(1, 0, `FN_QAE, 0, `RC_DONE, 24'h00_0000, 0);
  endtask : t_abort
  task automatic t_clear;
    do_reset;
    add(16'h0011, 2'd2);
    add(16'h0022, 2'd3);
    tm(2, 0, `FN_CTS, 0, `RC_DONE, 0, 8'h03);
    tm(3, 0, `FN_QAE, 0, `RC_OK, {2'b00, `DEP_ONE, `SK_UA, `ASC_CLR}, 0);
    tm(2, 0, `FN_QAE, 0, `RC_DONE, 0, 0);
    do_reset;
    add(16'h0033, 2'd1);
    add(16'h0044, 2'd2);
    tm(0, 0, `FN_LUR, 0, `RC_DONE, 0, 8'h03);
    @(posedge clock) {def_err, def_key, def_code} <= {1'b1, 4'h3, 16'h1100};
    tm(0, 0, `FN_QAE, 0, `RC_OK, {2'b00, `DEP_MANY, `SK_UA, `ASC_RST}, 0);
    ua_pulse(0);
    tm(0, 0, `FN_QAE, 0, `RC_OK, {2'b00, `DEP_ONE, 4'h3, 16'h1100}, 0);
    @(posedge clock) def_err <= 1'b0;
  endtask : t_clear
  task automatic t_unsup;
    logic [7:0] codes[5] = '{`FN_ACA, 8'h03, 8'h20, 8'hff, 8'h00};
    foreach (codes[i]) tm(0, 0, codes[i], 0, `RC_NSUP, 0, 0);
  endtask : t_unsup
  task automatic t_xfer;
    logic [7:0] ex[13] = '{`FT_XRDY, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 0, 0, 0, 0};
    logic [31:0] v;
    int w0;
    wr32(`R_XOFF, 32'h0000_1003);
    rd32(`R_XOFF, v);
    chk("xoff", 32'h0000_1000, v);
    wr32(`R_XLEN, 32'h0000_0010);
    u_init.txq.delete();
    wr32(`R_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clock);
    chk("xrdy_len", 13, 32'(u_init.txq.size()));
    chk("xrdy_last", 12, 32'(u_init.last_at));
    foreach (ex[i]) chk("xrdy_byte", {24'h0, ex[i]}, {24'h0, u_init.txq[i]});
    w0 = wr_cnt;
    u_init.send_data(0, 16);
    repeat (4) @(posedge clock);
    rd32(`R_WCNT, v);
    chk("wcnt", 32'h0000_0010, v);
    chk("wr_pulses", 16, 32'(wr_cnt - w0));
    chk("wr_byte", 32'h0000_0027, {24'h0, wr_last});
    u_init.send_data(0, 4);
    repeat (4) @(posedge clock);
    rd32(`R_STAT, v);
    chk("overrun", 1, {31'h0, v[2]});
    chk("over_drop", 16, 32'(wr_cnt - w0));
    wr32(`R_CTRL, 32'h0000_0002);
    rd32(`R_STAT, v);
    chk("overrun_clr", 0, {31'h0, v[2]});
    rd32(8'h20, v);
    chk("unmapped", 0, v);
  endtask : t_xfer
  task automatic t_read;
    u_init.txq.delete();
    u_init.last_at = -1;
    @(posedge clock);
    // next byte goes up right after the edge that took the previous one
    for (int i = 0; i < 3; i++) begin
      {src_valid, src_byte, src_last} <= {1'b1, 8'(8'ha1 + i), i == 2};
      do @(posedge clock); while (src_ready_q !== 1'b1);
    end
    {src_valid, src_byte, src_last} <= {1'b0, 8'h5c, 1'b0};
    repeat (10) @(posedge clock);
    chk("rd_len", 4, 32'(u_init.txq.size()));
    chk("rd_type", {24'h0, `FT_DATA}, {24'h0, u_init.txq[0]});
    for (int i = 1; i < 4; i++) chk("rd_byte", 32'(8'ha0 + i), {24'h0, u_init.txq[i]});
    chk("rd_last", 3, 32'(u_init.last_at));
  endtask : t_read
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    results;
  end
  initial begin
    t_abort;
    t_clear;
    t_unsup;
    t_xfer;
    t_read;
    results;
  end
endmodule : test_ssp_task_mgmt_and_xfer_ready
